// File: nusd_defs.vh
// Constants for the noise update step decider.
// Fixed point: thresholds in Q8.8 (value*256) unless noted; estimates unsigned Q16.16.
`ifndef NUSD_DEFS_VH
`define NUSD_DEFS_VH
// Register byte offsets
`define NUSD_OFF_CTRL      12'h000
`define NUSD_OFF_STATUS    12'h004
`define NUSD_OFF_FEAT0     12'h008
`define NUSD_OFF_FEAT1     12'h00C
`define NUSD_OFF_FEAT2     12'h010
`define NUSD_OFF_FEAT3     12'h014
`define NUSD_OFF_BAND_IDX  12'h018
`define NUSD_OFF_BAND_EST  12'h01C
`define NUSD_OFF_BAND_CAND 12'h020
`define NUSD_OFF_RATE      12'h024
`define NUSD_OFF_COUNT     12'h028
// Control bits
`define NUSD_CTRL_START    0
`define NUSD_CTRL_WIDEBW   1
`define NUSD_CTRL_DTX      2
`define NUSD_CTRL_MODE3    3
// Geometry
`define NUSD_NBANDS        20
`define NUSD_BAND_W        5
// Thresholds (Q8.8, except NUSD_TH_CFU_30 and NUSD_INIT_FRAMES, which are plain counts)
`define NUSD_TH_NTR        16'h012C
`define NUSD_TH_CEV_MUS    16'h00E6
`define NUSD_TH_APRED_FULL 16'h00D9
`define NUSD_TH_NDIST      16'h2800
`define NUSD_TH_CHARMB     16'h5000
`define NUSD_TH_PCOUNT     16'h0080
`define NUSD_TH_APRED_80   16'h00CD
`define NUSD_TH_APRED_70   16'h00B3
`define NUSD_TH_CHARM_50   16'h3200
`define NUSD_TH_APRED_60   16'h009A
`define NUSD_TH_CHARM_100  16'h6400
`define NUSD_TH_HACO_10    16'h001A
`define NUSD_TH_HACO_15    16'h0026
`define NUSD_TH_CHARM_80   16'h5000
`define NUSD_TH_CFU_30     16'h001E
`define NUSD_INIT_FRAMES   16'h0096
// Estimate constants
`define NUSD_EMIN2         32'h00000002
`define NUSD_MUL_098       16'h00FB
`define NUSD_RATE_W        16'h0033
`define NUSD_RATE_ONE      16'h0100
// Step codes
`define NUSD_STEP_0        2'h0
`define NUSD_STEP_1        2'h1
`define NUSD_STEP_01       2'h2
`define NUSD_STEP_001      2'h3
`endif

// File: nusd_band_math.v
// Per-band update arithmetic for one noise estimate.
// Assumes unsigned Q16.16 estimates; purely combinational.
`timescale 1ns/1ps
`include "nusd_defs.vh"
module nusd_band_math (
  input  wire [1:0]  step,
  input  wire        music,
  input  wire [31:0] est,
  input  wire [31:0] cand,
  output reg  [31:0] nxt_est
);
  reg [47:0] prod;
  reg [31:0] diff;
  reg        up;
  // Move the estimate toward the candidate by the chosen step; step 0 with music scales an estimate above NUSD_EMIN2 by NUSD_MUL_098
  always @* begin
    prod    = 48'h0;
    up      = (cand >= est);
    diff    = up ? (cand - est) : (est - cand);
    nxt_est = est;
    case (step)
      `NUSD_STEP_1: nxt_est = cand;
      `NUSD_STEP_01: begin
        nxt_est = up ? est + diff / 32'hA : est - diff / 32'hA;
      end
      `NUSD_STEP_001: begin
        nxt_est = up ? est + diff / 32'h64 : est - diff / 32'h64;
      end
      default: begin
        if (music && est > `NUSD_EMIN2) begin
          prod    = est * `NUSD_MUL_098;
          nxt_est = prod[39:8];
        end
      end
    endcase
  end
endmodule

// File: nusd_top.v
// Noise update step decider with activity flag combiner, APB slave.
// Assumes upstream stages write features then pulse start once per frame.
`timescale 1ns/1ps
`include "nusd_defs.vh"
module nusd_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         frame_done,
  output reg         local_activity_high_eff,
  output reg         local_activity_flag,
  output reg         combined_activity_flag,
  output reg         activity_with_hangover
);
  // Sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_BAND = 2'h1;
  localparam ST_DONE = 2'h2;

  // Band memories, not reset: software loads them before the first frame
  reg [31:0] band_noise_estimate [0:`NUSD_NBANDS-1];
  reg [31:0] band_cand_ff [0:`NUSD_NBANDS-1];
  // Register file written over the bus
  reg [31:0] feat0_ff, feat1_ff, feat2_ff, feat3_ff;
  reg [3:0]  ctrl_ff;
  reg [4:0]  bidx_ff;
  // Frame sequencer state
  reg [1:0]  state_ff;
  reg [4:0]  band_ff;
  reg [1:0]  step_ff;
  reg        music_ff;
  // Prevented-update counter, smoothed rate and frame count
  reg [15:0] cfu_ff;
  reg [15:0] rate_ff;
  reg [15:0] frames_ff;
  // Hangover frames still to run
  reg [3:0]  hang_ff;

  // Flag inputs from the low half of the status word, one bit each
  reg  [15:0] fl_ff;
  // Pitch count from the high half of the status word, Q8.8
  reg  [15:0] pcount_ff;

  // Feature fields, Q8.8 each
  wire [15:0] ntr_cnt              = feat0_ff[15:0];
  wire [15:0] longterm_correlation = feat0_ff[31:16];
  wire [15:0] apred                = feat1_ff[15:0];
  wire [15:0] act_pred             = feat1_ff[31:16];
  wire [15:0] charm                = feat2_ff[15:0];
  wire [15:0] charmb               = feat2_ff[31:16];
  wire [15:0] ndist                = feat3_ff[15:0];
  wire [15:0] chaco                = feat3_ff[31:16];

  // Mask and the four pause detectors
  wire        pause_nonupdate_ok   = fl_ff[0];
  wire        bg_mask              = fl_ff[1];
  wire        bg_dyn               = fl_ff[2];
  wire        bg_track             = fl_ff[3];
  wire        bg_new               = fl_ff[4];
  // Start-up and full-step helper terms
  wire        ini_raw              = fl_ff[5];
  wire        near_dist            = fl_ff[6];
  wire        ini_pause            = fl_ff[7];
  // Small-step helper terms and long-term noise level
  wire        pau_a                = fl_ff[8];
  wire        pau_b                = fl_ff[9];
  wire        harm_low_lvl         = fl_ff[10];
  wire        drop_alt             = fl_ff[11];
  wire        lt_noise             = fl_ff[12];
  // Sub-detector decisions for the activity combiner
  wire        first_subdetector    = fl_ff[13];
  wire        second_subdetector   = fl_ff[14];
  wire        third_detector_flag  = fl_ff[15];
  // Nonupdate metric at zero feeds the rate smoother
  wire        pnup_zero            = pause_nonupdate_ok;
  // Pitch count above one half
  wire        pcount_ok            = (pcount_ff > `NUSD_TH_PCOUNT);

  // Update permission; the start-up term bypasses the mask
  wire init_update_ok = ini_raw && (frames_ff < `NUSD_INIT_FRAMES);
  wire upd_ok = (bg_mask && (pause_nonupdate_ok || bg_dyn || bg_track || bg_new))
                || init_update_ok;

  // Music test, used only when no update is allowed
  wire is_music = (ntr_cnt > `NUSD_TH_NTR) && (longterm_correlation > `NUSD_TH_CEV_MUS)
                  && lt_noise;

  // Full step: prediction limit, pause flag and one of three alternatives
  wire alt_a = near_dist && (ndist < `NUSD_TH_NDIST);
  wire alt_b = (cfu_ff == 16'h0000) && (charmb > `NUSD_TH_CHARMB)
               && pcount_ok;
  wire alt_c = init_update_ok && ini_pause;
  wire full_ok = (apred < `NUSD_TH_APRED_FULL) && pause_nonupdate_ok
                 && (alt_a || alt_b || alt_c);

  // Tenth step: any of four conditions, three of them pause-based
  wire tenth_act = (act_pred < `NUSD_TH_APRED_80) && (pause_nonupdate_ok || pau_a)
                   && (chaco < `NUSD_TH_HACO_10);
  wire tenth_pause = (act_pred < `NUSD_TH_APRED_70) && pau_b
                     && (chaco < `NUSD_TH_HACO_15);
  wire tenth_stuck = (charm > `NUSD_TH_CHARM_50) && (cfu_ff > `NUSD_TH_CFU_30)
                     && pause_nonupdate_ok && pcount_ok;
  wire tenth_ok = tenth_act || tenth_pause
                  || harm_low_lvl || tenth_stuck;

  // Hundredth step: pause clear, low count and one further term
  wire drop_ok = !pause_nonupdate_ok && (charm < `NUSD_TH_CHARM_50)
                 && ((apred > `NUSD_TH_APRED_60) || drop_alt);

  // Counter increment when no step was taken
  wire fail_cnt = pause_nonupdate_ok || (charm > `NUSD_TH_CHARM_100);

  reg [1:0] nxt_step;
  // Step selection for the frame
  always @* begin
    nxt_step = `NUSD_STEP_0;
    if (upd_ok) begin
      if (full_ok)
        nxt_step = `NUSD_STEP_1;
      else if (tenth_ok)
        nxt_step = drop_ok ? `NUSD_STEP_001 : `NUSD_STEP_01;
    end
  end

  // Band arithmetic for the band in turn
  wire [31:0] nxt_band;
  nusd_band_math u_math (
    .step    (step_ff),
    .music   (music_ff),
    .est     (band_noise_estimate[band_ff]),
    .cand    (band_cand_ff[band_ff]),
    .nxt_est (nxt_band)
  );

  // Smoothed update rate, Q8.8
  wire [31:0] rate_mix = rate_ff * (`NUSD_RATE_ONE - `NUSD_RATE_W)
                         + (pnup_zero ? `NUSD_RATE_ONE * `NUSD_RATE_W : 32'h0);

  // Bus write strobe and frame start
  wire        apb_wr = psel && penable && pwrite && pready;
  wire        start  = apb_wr && (paddr == `NUSD_OFF_CTRL) && pwdata[`NUSD_CTRL_START];

  // Frame sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= ST_IDLE;
      band_ff    <= 5'h00;
      step_ff    <= `NUSD_STEP_0;
      music_ff   <= 1'b0;
      cfu_ff     <= 16'h0000;
      rate_ff    <= 16'h0000;
      frames_ff  <= 16'h0000;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      case (state_ff)
        // Decide the step and latch the music test on start
        ST_IDLE: begin
          if (start) begin
            step_ff  <= nxt_step;
            music_ff <= !upd_ok && is_music;
            band_ff  <= 5'h00;
            state_ff <= ST_BAND;
            if (nxt_step != `NUSD_STEP_0)
              cfu_ff <= 16'h0001;
            else if (upd_ok && fail_cnt && cfu_ff != 16'hFFFF)
              cfu_ff <= cfu_ff + 16'h0001;
          end
        end
        // One band per cycle
        ST_BAND: begin
          if (band_ff == `NUSD_NBANDS - 1)
            state_ff <= ST_DONE;
          else
            band_ff <= band_ff + 5'h01;
        end
        // Close the frame
        ST_DONE: begin
          rate_ff    <= rate_mix[23:8];
          if (frames_ff != 16'hFFFF)
            frames_ff <= frames_ff + 16'h0001;
          frame_done <= 1'b1;
          state_ff   <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Band memory: sequencer writes estimates in band phase, software outside it; software writes candidates in any state
  always @(posedge pclk) begin
    if (state_ff == ST_BAND)
      band_noise_estimate[band_ff] <= nxt_band;
    else if (apb_wr && paddr == `NUSD_OFF_BAND_EST)
      band_noise_estimate[bidx_ff] <= pwdata;
    if (apb_wr && paddr == `NUSD_OFF_BAND_CAND)
      band_cand_ff[bidx_ff] <= pwdata;
  end

  // Activity combination with hangover
  wire prelim   = ctrl_ff[`NUSD_CTRL_WIDEBW] ? (first_subdetector || second_subdetector)
                                            : first_subdetector;
  wire merged   = ctrl_ff[`NUSD_CTRL_MODE3] ? (prelim || third_detector_flag) : prelim;

  // Hangover counter and output flags, updated once per frame
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hang_ff                 <= 4'h0;
      local_activity_high_eff <= 1'b0;
      local_activity_flag     <= 1'b0;
      combined_activity_flag  <= 1'b0;
      activity_with_hangover  <= 1'b0;
    end else if (state_ff == ST_DONE) begin
      hang_ff <= merged ? 4'h7 : (hang_ff != 4'h0 ? hang_ff - 4'h1 : 4'h0);
      local_activity_high_eff <= first_subdetector;
      local_activity_flag     <= first_subdetector;
      activity_with_hangover  <= merged || (hang_ff != 4'h0);
      combined_activity_flag  <= ctrl_ff[`NUSD_CTRL_DTX] ? (merged || hang_ff != 4'h0)
                                                        : merged;
    end
  end

  // APB register writes and reads, zero wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff  <= 4'h0;
      bidx_ff  <= 5'h00;
      feat0_ff <= 32'h0;
      feat1_ff <= 32'h0;
      feat2_ff <= 32'h0;
      feat3_ff <= 32'h0;
      fl_ff    <= 16'h0000;
      pcount_ff <= 16'h0000;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          `NUSD_OFF_CTRL:     ctrl_ff  <= {pwdata[3:1], 1'b0};
          `NUSD_OFF_STATUS: begin
            fl_ff     <= pwdata[15:0];
            pcount_ff <= pwdata[31:16];
          end
          `NUSD_OFF_FEAT0:    feat0_ff <= pwdata;
          `NUSD_OFF_FEAT1:    feat1_ff <= pwdata;
          `NUSD_OFF_FEAT2:    feat2_ff <= pwdata;
          `NUSD_OFF_FEAT3:    feat3_ff <= pwdata;
          `NUSD_OFF_BAND_IDX: bidx_ff  <= pwdata[4:0];
          default: ;
        endcase
      end
      if (psel && !penable) begin
        case (paddr)
          `NUSD_OFF_CTRL:      prdata <= {26'h0, step_ff, ctrl_ff[3:1], state_ff != ST_IDLE};
          `NUSD_OFF_STATUS:    prdata <= {pcount_ff, fl_ff};
          `NUSD_OFF_FEAT0:     prdata <= feat0_ff;
          `NUSD_OFF_FEAT1:     prdata <= feat1_ff;
          `NUSD_OFF_FEAT2:     prdata <= feat2_ff;
          `NUSD_OFF_FEAT3:     prdata <= feat3_ff;
          `NUSD_OFF_BAND_IDX:  prdata <= {27'h0, bidx_ff};
          `NUSD_OFF_BAND_EST:  prdata <= band_noise_estimate[bidx_ff];
          `NUSD_OFF_BAND_CAND: prdata <= band_cand_ff[bidx_ff];
          `NUSD_OFF_RATE:      prdata <= {16'h0, rate_ff};
          `NUSD_OFF_COUNT:     prdata <= {cfu_ff, frames_ff};
          default: begin
            prdata  <= 32'h0;
          end
        endcase
      end
      // Addresses past the last register answer with an error
      if (psel && !penable && paddr > `NUSD_OFF_COUNT)
        pslverr <= 1'b1;
    end
  end
endmodule

// File: nusd_chk.sv
// Port checker for the noise update step decider.
// Assumes it is bound to nusd_top and sees its ports only.
`timescale 1ns/1ps
module nusd_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        frame_done,
  input wire        local_activity_high_eff,
  input wire        local_activity_flag,
  input wire        combined_activity_flag,
  input wire        activity_with_hangover
);
  // All checks run on the bus clock and stop during reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_one_a: assert property (pready |=> !pready) else $error("pready held");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer to setup");
  ready_cause_a: assert property (pready |-> penable && $past(psel && !penable))
    else $error("pready without setup");
  err_map_a: assert property (pready |-> pslverr == (paddr > 12'h028))
    else $error("pslverr wrong");
  rdata_zero_a: assert property (pready && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read data");
  done_pulse_a: assert property (frame_done |=> !frame_done) else $error("long done");
  frame_len_a: assert property (pready && pwrite && paddr == 12'h000 && pwdata[0]
    |=> (!frame_done)[*8] ##[12:18] frame_done) else $error("frame length");
  flag_time_a: assert property ($changed(local_activity_flag)
    |-> frame_done || $past(frame_done)) else $error("flag moved mid frame");
  hang_cover_a: assert property (combined_activity_flag |-> activity_with_hangover)
    else $error("hangover flag low");
endmodule
bind nusd_top nusd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
  .local_activity_high_eff(local_activity_high_eff),
  .local_activity_flag(local_activity_flag),
  .combined_activity_flag(combined_activity_flag),
  .activity_with_hangover(activity_with_hangover));

// File: nusd_upstream_model.sv
// Upstream feature stage model: APB master loading features and starting frames.
// Assumes an APB slave on pclk answering with pready.
`timescale 1ns/1ps
module nusd_upstream_model (
  input  wire        pclk,
  input  wire        pready,
  input  wire [31:0] prdata,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata
);
  // Bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer: setup, access held until pready, then release
  task automatic xfer(input w, input [11:0] a, input [31:0] d,
                      output [31:0] r, output ok);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (!pready && n < 16);
      r = prdata;
      ok = pready;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // Released data no longer shows the last word
    end
  endtask
endmodule

// File: noise_update_step_decider_tb.sv
// Self-checking bench for the noise update step decider.
// Assumes the upstream model as bus master and the bound port checker.
`timescale 1ns/1ps
module noise_update_step_decider_tb;
  reg         pclk;
  reg         presetn;
  wire        psel, penable, pwrite, pready, pslverr, frame_done;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire        lahe, laf, caf, awh;
  integer     miscompares;
  integer     checked;
  reg  [31:0] r;
  nusd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_done(frame_done), .local_activity_high_eff(lahe),
    .local_activity_flag(laf), .combined_activity_flag(caf), .activity_with_hangover(awh));
  nusd_upstream_model up (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // Clock generator
  always #5 pclk = ~pclk;
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    reg ok;
    begin
      up.xfer(w, a, d, r, ok);
      if (!ok) begin
        miscompares = miscompares + 1;
        final_report;
      end
    end
  endtask
  task band(input [31:0] i, input [31:0] e, input [31:0] c);
    bus(1, 12'h018, i);
    bus(1, 12'h01C, e);
    bus(1, 12'h020, c);
  endtask
  task est(input [31:0] i, input [31:0] exp);
    bus(1, 12'h018, i);
    bus(0, 12'h01C, 0);
    chk("band estimate", r, exp);
  endtask
  // Load inputs, start one frame, wait for its end
  task frame(input [3:0] c, input [15:0] s, input [31:0] f0, f1, f2, f3);
    integer n;
    begin
      bus(1, 12'h004, {16'h0, s});
      bus(1, 12'h008, f0);
      bus(1, 12'h00C, f1);
      bus(1, 12'h010, f2);
      bus(1, 12'h014, f3);
      bus(1, 12'h000, {28'h0, c[3:1], 1'b1});
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (!frame_done && n < 100);
      if (n >= 100) begin
        miscompares = miscompares + 1;
        final_report;
      end
    end
  endtask
  task step_cnt(input [1:0] s, input [15:0] c);
    bus(0, 12'h000, 0);
    chk("step code", r[5:4], s);
    bus(0, 12'h028, 0);
    chk("counter", r[31:16], c);
  endtask
  task t_reset;
    bus(0, 12'h028, 0);
    chk("count reset", r, 0);
    bus(0, 12'h024, 0);
    chk("rate reset", r, 0);
    bus(0, 12'h02C, 0);
    chk("unmapped read", r, 0);
  endtask
  task t_full;
    band(0, 32'h10000, 32'h30000);
    frame(0, 16'h0043, 0, 32'h0080, 0, 32'h0100);
    est(0, 32'h30000);
    step_cnt(1, 1);
    chk("frames", r[15:0], 1);
    bus(0, 12'h024, 0);
    chk("rate", r, 32'h33);
  endtask
  task t_music;
    integer k;
    band(0, 32'h10000, 0);
    band(1, 2, 0);
    for (k = 0; k < 2; k = k + 1) begin
      frame(0, 16'h1000, {16'h00F0, 16'h012D - k[15:0]}, 0, 0, 0);
      est(0, 32'hFB00);
    end
    est(1, 2);
    step_cnt(0, 1);
  endtask
  task t_small;
    band(0, 32'h10000, 32'h1A000);
    frame(0, 16'h0003, 0, 32'h008000E0, 0, 32'h00100000);
    est(0, 32'h11000);
    step_cnt(2, 1);
    band(0, 32'h10000, 32'h74000);
    frame(0, 16'h0406, 0, 32'h00C0, 32'h0100, 0);
    est(0, 32'h11000);
    step_cnt(3, 1);
  endtask
  task t_zero;
    integer k;
    for (k = 0; k < 2; k = k + 1) begin
      frame(0, 16'h0006, 0, 0, 32'h6500 - k * 32'h0100, 0);
      step_cnt(0, 2);
    end
  endtask
  task flagcase(input [3:0] c, input [15:0] s, input [3:0] exp);
    frame(c, s, 0, 0, 0, 0);
    @(posedge pclk);
    #1;
    chk("activity flags", {lahe, laf, caf, awh}, exp);
  endtask
  // Start-up update permission, then its expiry after the start-up frames
  task t_init;
    begin
      frame(0, 16'h0420, 0, 0, 0, 0);
      step_cnt(2, 1);
      repeat (140) frame(0, 0, 0, 0, 0, 0);
      frame(0, 16'h0420, 0, 0, 0, 0);
      step_cnt(0, 1);
    end
  endtask
  // Reset, then each scenario in turn
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_full;
    t_music;
    t_small;
    t_zero;
    flagcase(0, 16'h4000, 4'b0000);
    flagcase(0, 16'h2000, 4'b1111);
    flagcase(4'h4, 0, 4'b0011);
    flagcase(0, 0, 4'b0001);
    flagcase(4'h2, 16'h4000, 4'b0011);
    flagcase(0, 16'h8000, 4'b0001);
    flagcase(4'h8, 16'h8000, 4'b0011);
    t_init;
    final_report;
  end
endmodule
